// >>> rtl/ret_decode.sv
// Purpose: decode a fetched word into one of the three return kinds
// Assumes: word is stable while ir_valid is high
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module ret_decode
  import ret_exec_pkg::*;
(
  input  wire logic [15:0] instr,
  output ret_dec_s         dec
);

  function automatic logic hit(input logic [15:0] w, input logic [15:0] m,
                               input logic [15:0] v);
    hit = ((w & m) == v);
  endfunction

  // literal return carries no fast flag; the low byte is the immediate
  always_comb
  begin
    dec.kind    = RK_NONE;
    dec.fast    = 1'b0;
    dec.literal = instr[7:0];
    if (hit(instr, IRET_MASK, IRET_MATCH))
    begin
      dec.kind = RK_IRET;
      dec.fast = instr[FAST_BIT];
    end
    else if (hit(instr, SRET_MASK, SRET_MATCH))
    begin
      dec.kind = RK_SRET;
      dec.fast = instr[FAST_BIT];
    end
    else if (hit(instr, LRET_MASK, LRET_MATCH))
      dec.kind = RK_LRET;
  end

endmodule
`default_nettype wire

// >>> rtl/ret_exec.sv
// Purpose: execute interrupt, literal and subroutine returns
// Assumes: the core presents each new instruction at phase one with ir_valid
// Notes:   pc high/upper latches are never driven by this block
//          ce low freezes phase, state and strobes alike
//          words offered while busy are dropped without any sign
//          strobes leave flops, so they trail their cause by one mclk
//          reset clears held values as well as strobes
`timescale 1ns/100ps
`default_nettype none
module ret_exec
  import ret_exec_pkg::*;
#(
  parameter int PCW = PC_W
)
(
  input  wire logic           mclk,
  input  wire logic           rst,
  input  wire logic           ce,
  input  wire logic           ir_valid,
  input  wire logic [15:0]    instr,
  input  wire logic           high_priority_mode,
  input  wire logic [PCW-1:0] stack_top_entry,
  input  wire ctx_s           shadow_ctx,
  output logic                busy,
  output logic [1:0]          phase,
  output logic                stack_pop,
  output logic                pc_load,
  output logic [PCW-1:0]      pc_value,
  output logic                working_load,
  output logic [7:0]          working_value,
  output logic                ctx_restore,
  output ctx_s                ctx_value,
  output logic                high_priority_global_enable_set,
  output logic                low_priority_global_enable_set,
  output logic                prefetch_flush,
  output logic                done
);

  // two instruction cycles, four phases each
  typedef enum logic [1:0] {
    S_IDLE,
    S_FIRST,
    S_SECOND
  } st_e;

  // decoded view of the current word
  ret_dec_s dec;

  // decoder runs every cycle; only idle listens to it
  ret_decode u_dec (
    .instr (instr),
    .dec   (dec)
  );

  // sequencer state
  st_e            st_q, st_d;
  logic [1:0]     ph_q, ph_d;
  ret_dec_s       cur_q, cur_d;
  // strobes and the values they carry
  logic           pop_q, pop_d;
  logic           pcl_q, pcl_d;
  logic [PCW-1:0] pcv_q, pcv_d;
  logic           wl_q, wl_d;
  logic [7:0]     wv_q, wv_d;
  logic           cr_q, cr_d;
  ctx_s           cv_q, cv_d;
  // enable strobes, flush and end of return
  logic           gh_q, gh_d;
  logic           gl_q, gl_d;
  logic           fl_q, fl_d;
  logic           dn_q, dn_d;

  // phase four of the current instruction cycle
  wire logic last_ph = (ph_q == PHASE_LAST);

  // phase advance; two bits wrap from four back to one by themselves
  function automatic logic [1:0] next_phase(input logic [1:0] p);
    next_phase = p + 2'h1;
  endfunction

  // sequencer and phase-four actions; strobes last one mclk each while ce stays high
  always_comb
  begin
    // strobes default low; values hold until the next load
    st_d  = st_q;
    ph_d  = ph_q;
    cur_d = cur_q;
    pop_d = 1'b0;
    pcl_d = 1'b0;
    pcv_d = pcv_q;
    wl_d  = 1'b0;
    wv_d  = wv_q;
    cr_d  = 1'b0;
    cv_d  = cv_q;
    gh_d  = 1'b0;
    gl_d  = 1'b0;
    fl_d  = 1'b0;
    dn_d  = 1'b0;
    case (st_q)
      S_IDLE:
      begin
        ph_d = PHASE_RST;
        // only a return opcode starts a sequence
        if (ir_valid && dec.kind != RK_NONE)
        begin
          cur_d = dec;
          st_d  = S_FIRST;
          ph_d  = 2'h1; // decode consumed phase one
        end
      end
      S_FIRST:
      begin
        // phases two and three wait; phase four does the work
        ph_d = next_phase(ph_q);
        if (last_ph)
        begin
          // pop and pc write together; latches untouched
          pop_d = 1'b1;
          pcl_d = 1'b1;
          pcv_d = stack_top_entry;
          if (cur_q.kind == RK_LRET)
          begin
            wl_d = 1'b1;
            wv_d = cur_q.literal;
          end
          if (cur_q.kind != RK_LRET && cur_q.fast)
          begin
            cr_d = 1'b1;
            cv_d = shadow_ctx;
          end
          if (cur_q.kind == RK_IRET)
          begin
            gh_d = high_priority_mode;
            gl_d = !high_priority_mode;
          end
          st_d = S_SECOND;
          ph_d = PHASE_RST;
        end
      end
      S_SECOND:
      begin
        // dead cycle: stale fetch dropped
        ph_d = next_phase(ph_q);
        // flush on the first edge of the dead cycle
        if (ph_q == PHASE_RST)
          fl_d = 1'b1;
        if (last_ph)
        begin
          // phase four of cycle two ends the return
          dn_d = 1'b1; // two cycles in all
          st_d = S_IDLE;
          ph_d = PHASE_RST;
        end
      end
      default:
      begin
        // unused encoding: fall back to idle
        st_d = S_IDLE;
        ph_d = PHASE_RST;
      end
    endcase
  end

  // state held while ce is low
  // ce gates every flop, so a stalled core sees no half step
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      // constants only, so reset never depends on live data
      st_q  <= S_IDLE;
      ph_q  <= PHASE_RST;
      cur_q <= '0;
      pop_q <= 1'b0;
      pcl_q <= 1'b0;
      pcv_q <= '0;
      wl_q  <= 1'b0;
      wv_q  <= 8'h00;
      cr_q  <= 1'b0;
      cv_q  <= '0;
      gh_q  <= 1'b0;
      gl_q  <= 1'b0;
      fl_q  <= 1'b0;
      dn_q  <= 1'b0;
    end
    else if (ce)
    begin
      st_q  <= st_d;
      ph_q  <= ph_d;
      cur_q <= cur_d;
      pop_q <= pop_d;
      pcl_q <= pcl_d;
      pcv_q <= pcv_d;
      wl_q  <= wl_d;
      wv_q  <= wv_d;
      cr_q  <= cr_d;
      cv_q  <= cv_d;
      gh_q  <= gh_d;
      gl_q  <= gl_d;
      fl_q  <= fl_d;
      dn_q  <= dn_d;
    end
  end

  // outputs from flops; busy is decoded from the state flops
  assign busy                            = (st_q != S_IDLE);
  assign phase                           = ph_q;

  // strobes and held values
  assign stack_pop                       = pop_q;
  assign pc_load                         = pcl_q;
  assign pc_value                        = pcv_q;
  assign working_load                    = wl_q;
  assign working_value                   = wv_q;
  assign ctx_restore                     = cr_q;
  assign ctx_value                       = cv_q;
  assign high_priority_global_enable_set = gh_q;
  assign low_priority_global_enable_set  = gl_q;
  assign prefetch_flush                  = fl_q;
  assign done                            = dn_q;

endmodule
`default_nettype wire

// >>> shared/ret_exec_pkg.sv
// Purpose: constants and carriers for the return-instruction execution block
// Assumes: 16-bit instruction words, 21-bit program counter, four phases per cycle
// Notes:   opcode masks, phase constants and carriers
package ret_exec_pkg;

  localparam int PC_W = 21;

  localparam logic [15:0] IRET_MASK  = 16'hfffe;
  localparam logic [15:0] IRET_MATCH = 16'h0010;
  localparam logic [15:0] SRET_MASK  = 16'hfffe;
  localparam logic [15:0] SRET_MATCH = 16'h0012;
  localparam logic [15:0] LRET_MASK  = 16'hff00;
  localparam logic [15:0] LRET_MATCH = 16'h0c00;

  localparam int FAST_BIT = 0;

  // phase counter: 0..3 stands for phases one to four
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_RST  = 2'h0;

  // instruction cycles taken by every return
  localparam logic [1:0] RET_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    RK_NONE,
    RK_IRET,
    RK_SRET,
    RK_LRET
  } ret_kind_e;

  // shadow set captured on interrupt entry / call fast
  typedef struct packed {
    logic [7:0] working;
    logic [7:0] flags;
    logic [7:0] bank;
  } ctx_s;

  // decoded return instruction
  typedef struct packed {
    ret_kind_e  kind;
    logic       fast;
    logic [7:0] literal;
  } ret_dec_s;

endpackage

// >>> verif/ret_exec_assertions.sv
// Purpose: port assertions for ret_exec
// Assumes: ce drops only before the pop; instr holds until the pop
// Notes:   bound to every ret_exec instance
`timescale 1ns/100ps
`default_nettype none
module ret_exec_chk
  import ret_exec_pkg::*;
#(
  parameter int PCW = PC_W
)
(
  input wire logic           mclk,
  input wire logic           rst,
  input wire logic [15:0]    instr,
  input wire logic [PCW-1:0] stack_top_entry,
  input wire ctx_s           shadow_ctx,
  input wire logic           stack_pop,
  input wire logic           pc_load,
  input wire logic [PCW-1:0] pc_value,
  input wire logic           working_load,
  input wire logic [7:0]     working_value,
  input wire logic           ctx_restore,
  input wire ctx_s           ctx_value,
  input wire logic           high_priority_global_enable_set,
  input wire logic           low_priority_global_enable_set,
  input wire logic           prefetch_flush,
  input wire logic           done
);
  // strobes last one cycle; checks are anchored on a strobe, a_pc_hold on no load, a_pop_with_load on nothing
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_pop_with_load: assert property (stack_pop == pc_load)
    else $error("pop and pc load apart");
  a_flush_next: assert property (pc_load |=> prefetch_flush && !pc_load)
    else $error("no flush after load");
  a_done_bound: assert property (pc_load |-> ##4 done)
    else $error("done not four cycles after load");
  a_pc_popped: assert property (pc_load |-> pc_value == $past(stack_top_entry))
    else $error("pc not the popped entry");
  a_pc_hold: assert property (!pc_load |-> $stable(pc_value))
    else $error("pc value moved without load");
  a_ctx_shadow: assert property (ctx_restore |-> pc_load &&
    ctx_value == $past(shadow_ctx))
    else $error("shadow restore wrong");
  a_lit_value: assert property (working_load |-> !ctx_restore &&
    working_value == $past(instr[7:0], 4))
    else $error("literal wrong");
  a_enable_one: assert property ((high_priority_global_enable_set ||
    low_priority_global_enable_set) |-> pc_load && !working_load &&
    !(high_priority_global_enable_set && low_priority_global_enable_set))
    else $error("enable set wrong");
endmodule
bind ret_exec ret_exec_chk #(.PCW(PCW)) u_chk (.*);
`default_nettype wire

// >>> verif/tb_return_instruction_execution.sv
// Purpose: self-checking bench for ret_exec
// Assumes: ce high except one stalled edge; one return in flight
// Notes:   table rows first, then refusal cases
`timescale 1ns/100ps
`default_nettype none
module tb_return_instruction_execution
  import ret_exec_pkg::*;
;
  typedef struct packed {
    logic [15:0] op;
    logic        hp;
    logic [3:0]  fl; // working, ctx, high, low
  } row_s;
  localparam row_s ROWS [6] = '{'{16'h0010, 1'h1, 4'h2}, '{16'h0011, 1'h0, 4'h5},
    '{16'h0012, 1'h0, 4'h0}, '{16'h0013, 1'h1, 4'h4}, '{16'h0c00, 1'h0, 4'h8},
    '{16'h0cff, 1'h1, 4'h8}};
  logic        mclk, rst, ce, ir_valid, hp, busy, pop, ld, wl, cr, hi, lo, fl, done;
  logic [15:0] instr;
  logic [20:0] top, pc;
  logic [7:0]  wv;
  logic [1:0]  phase;
  ctx_s        sh, cv;
  int          n_mismatch, compares, n;
  ret_exec dut (.mclk, .rst, .ce, .ir_valid, .instr, .high_priority_mode(hp),
    .stack_top_entry(top), .shadow_ctx(sh), .busy, .phase, .stack_pop(pop), .pc_load(ld),
    .pc_value(pc), .working_load(wl), .working_value(wv), .ctx_restore(cr), .ctx_value(cv),
    .high_priority_global_enable_set(hi), .low_priority_global_enable_set(lo),
    .prefetch_flush(fl), .done);
  // 200 MHz clock
  initial
  begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait on load or done, sampled at the falling edge
  task automatic wait_hi(input logic d);
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end while (!(d ? done : ld) && n < 12);
    if (n == 12)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // one return; poke offers a second word while busy, which must be dropped;
  // hold drops ce for the edge after acceptance; the wait starts after that edge and still counts four
  task automatic run(input row_s r, input logic [20:0] t, input ctx_s s, input logic poke,
                     input logic hold);
    @(posedge mclk);
    ir_valid <= 1'h1;
    instr <= r.op;
    hp <= r.hp;
    top <= t;
    sh <= s;
    @(posedge mclk);
    ir_valid <= 1'h0;
    ce <= !hold;
    if (hold)
    begin
      @(posedge mclk);
      ce <= 1'h1;
    end
    wait_hi(1'h0);
    chk(n, 4);
    chk({busy, phase}, 3'h4);
    chk({pop, wl, cr, hi, lo}, {1'h1, r.fl});
    chk(pc, t);
    if (r.fl[3]) chk(wv, r.op[7:0]);
    if (r.fl[2]) chk(cv, s);
    @(negedge mclk);
    chk(fl, 1);
    if (poke)
    begin
      @(posedge mclk);
      ir_valid <= 1'h1;
      instr <= 16'h0cff;
      @(posedge mclk);
      ir_valid <= 1'h0;
    end
    wait_hi(1'h1);
    chk(n, poke ? 2 : 3);
  endtask
  // reset, table, then refused words
  initial
  begin
    n_mismatch = 0;
    compares = 0;
    {rst, ce} = 2'h3;
    {ir_valid, hp, instr, top, sh} = '0;
    repeat (5) @(posedge mclk);
    chk({busy, phase, pop, ld, done}, 0);
    rst <= 1'h0;
    foreach (ROWS[i])
      run(ROWS[i], {5'h1f, 8'(i), 8'ha5}, {8'(i), 16'h3cc3}, 1'h0, 1'h0);
    run(ROWS[1], 21'h0f0f0f, 24'h123456, 1'h1, 1'h0);
    // reset in mid-return clears strobes and held values
    @(posedge mclk);
    ir_valid <= 1'h1;
    instr <= 16'h0013;
    @(posedge mclk);
    ir_valid <= 1'h0;
    wait_hi(1'h0);
    @(posedge mclk);
    rst <= 1'h1;
    @(negedge mclk);
    chk({busy, phase, pop, ld, wl, cr, hi, lo, fl, done}, 0);
    chk(pc, 0);
    chk(wv, 0);
    chk(cv, 0);
    // two edges of reset, then a literal return with ce dropped once
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    run(ROWS[5], 21'h00abcd, 24'h5a5a5a, 1'h0, 1'h1);
    @(posedge mclk);
    ir_valid <= 1'h1;
    instr <= 16'h0014;
    @(posedge mclk);
    ir_valid <= 1'h0;
    repeat (3) @(negedge mclk);
    chk(busy, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
